// file: verilog/canopen_node_params.svh
// constants of the canopen slave node
`ifndef CANOPEN_NODE_PARAMS_SVH
`define CANOPEN_NODE_PARAMS_SVH
`define DIG_N 11
`define ANA_N 13
`define MAP_N 6
`define SLOT_N 8
`define MAX_LEN 4'h8
`define COB_NMT 11'h000
`define COB_EMCY 11'h080
`define COB_GUARD 11'h700
`define RPDO1 11'h200
`define RPDO2 11'h300
`define RPDO3 11'h400
`define RPDO4 11'h500
`define RPDO5 11'h240
`define RPDO6 11'h340
`define TPDO1 11'h180
`define TPDO2 11'h280
`define TPDO3 11'h380
`define TPDO4 11'h480
`define TPDO5 11'h1C0
`define TPDO6 11'h2C0
`define CMD_START 8'h01
`define CMD_STOP 8'h02
`define CMD_PREOP 8'h80
`define CMD_RST_NODE 8'h81
`define CMD_RST_COMM 8'h82
`define GS_STOP 7'h04
`define GS_OPER 7'h05
`define GS_PREOP 7'h7F
`define BOOT_DATA 8'h00
`define ERR_N 4
`define ERR_CODE0 16'h1000
`define ERR_CODE1 16'h2000
`define ERR_CODE2 16'h3000
`define ERR_CODE3 16'h4000
`define ERR_REG_GEN 8'h01
`endif

// file: verilog/canopen_node_pkg.sv
// types of the canopen slave node
package canopen_node_pkg;
   typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_OPER, ST_STOP} nmt_state_t;
   typedef enum logic [1:0] {SRC_BOOT, SRC_GUARD, SRC_EMCY, SRC_TPDO} tx_src_t;
   typedef logic [6:0] map_slot_t;
endpackage

// file: verilog/canopen_node.sv
// canopen slave node: nmt states, pdo mapping, emergency and guard replies
`timescale 1ns/1ps
`default_nettype none
`include "canopen_node_params.svh"
// How it works
// - four or more transmit and receive mapping objects, each with default contents.
// - first mapping objects carry digital outputs and digital inputs.
// - second to fourth mapping objects carry analog outputs and analog inputs.
// - a digital entry takes one byte; first object holds eight entries.
// - an analog entry takes two bytes; four per object, rest spill over.
// - surplus digital entries go to object five, surplus analog to object six.
// - mappings are rewritable; both ends must agree before exchanging data.
// - received process data bytes are decoded by mapping and drive outputs.
// - a transmit trigger builds a frame from inputs in mapping order.
// - process data frames carry at most eight bytes.
// - each new internal error sends exactly one emergency frame.
// - a still-present error sends no further emergency frame.
// - a vanished error sends an emergency frame with zero error code.
// - emergency frame: code in bytes 0-1, error register 2, extra 3-7.
// - node id lies in 1..127; one master per bus.
// - power-on or hardware reset enters initialization.
// - initialization finished moves to pre-operational by itself.
// - start command in pre-operational or stopped enters operational.
// - pre-operational command in operational or stopped enters pre-operational.
// - stop command in pre-operational or operational enters stopped.
// - reset node or reset communication in any state but initialization returns to initialization.
// - process data sent and accepted only in operational.
// - boot-up only in init; services in pre-op/op; commands outside init.
// - only node guarding slave runs, never heartbeat alongside.
module canopen_node (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // pins
   input wire logic [6:0] node_id_pin,
   input wire logic [8*`DIG_N-1:0] din_pin,
   input wire logic [16*`ANA_N-1:0] ain_pin,
   // same-clock events
   input wire logic [`MAP_N-1:0] tx_trig,
   input wire logic [`ERR_N-1:0] err_in,
   // mapping write port
   input wire logic map_wr,
   input wire logic map_tx,
   input wire logic [2:0] map_obj,
   input wire logic [2:0] map_slot,
   input wire canopen_node_pkg::map_slot_t map_val,
   // received frame
   input wire logic rx_valid,
   input wire logic rx_rtr,
   input wire logic [10:0] rx_cob,
   input wire logic [3:0] rx_len,
   input wire logic [63:0] rx_data,
   // frame to send
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [10:0] tx_cob,
   output logic [3:0] tx_len,
   output logic [63:0] tx_data,
   // outputs and status
   output logic [8*`DIG_N-1:0] dout,
   output logic [16*`ANA_N-1:0] aout,
   output var canopen_node_pkg::nmt_state_t nmt_state,
   output logic pdo_en,
   output logic svc_en
);
   import canopen_node_pkg::*;
   localparam int DW = 8*`DIG_N;
   localparam int IW = DW + 16*`ANA_N;
   localparam logic [10:0] RX_BASE [`MAP_N] = '{`RPDO1, `RPDO2, `RPDO3, `RPDO4, `RPDO5, `RPDO6};
   localparam logic [10:0] TX_BASE [`MAP_N] = '{`TPDO1, `TPDO2, `TPDO3, `TPDO4, `TPDO5, `TPDO6};
   localparam logic [15:0] ERR_CODE [`ERR_N] = '{`ERR_CODE0, `ERR_CODE1, `ERR_CODE2, `ERR_CODE3};

   // default layout of one mapping slot
   function automatic map_slot_t def_map(int o, int s);
      int e;
      e = 0;
      case (o)
         0: e = s;
         4: e = 8 + s;
         5: e = 12 + s/2;
         default: e = (o-1)*4 + s/2;
      endcase
      if (o == 0 || o == 4) begin
         def_map = (e < `DIG_N) ? {2'b10, 4'(e), 1'b0} : '0;
      end else begin
         def_map = (e < `ANA_N) ? {2'b11, 4'(e), s[0]} : '0;
      end
   endfunction

   // pin synchronisers, change taken once stages two and three agree
   logic [IW-1:0] in_s1, in_s2, in_s3, in_st, next_in_st;
   logic [6:0] id_s1, id_s2, id_s3, id_st, next_id_st;
   always_comb begin
      next_in_st = (in_s3 & ~(in_s2 ^ in_s3)) | (in_st & (in_s2 ^ in_s3));
      next_id_st = (id_s3 & ~(id_s2 ^ id_s3)) | (id_st & (id_s2 ^ id_s3));
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         in_s1 <= '0;
         in_s2 <= '0;
         in_s3 <= '0;
         in_st <= '0;
         id_s1 <= '0;
         id_s2 <= '0;
         id_s3 <= '0;
         id_st <= '0;
      end else begin
         in_s1 <= {ain_pin, din_pin};
         in_s2 <= in_s1;
         in_s3 <= in_s2;
         in_st <= next_in_st;
         id_s1 <= node_id_pin;
         id_s2 <= id_s1;
         id_s3 <= id_s2;
         id_st <= next_id_st;
      end
   end

   // decoded commands
   nmt_state_t state, next_state;
   logic [6:0] node_id, next_node_id;
   logic [10:0] id11;
   logic nmt_hit, rst_node;
   logic [7:0] cmd;
   assign state = nmt_state;
   assign id11 = {4'h0, node_id};
   assign cmd = rx_data[7:0];
   assign nmt_hit = rx_valid && !rx_rtr && rx_cob == `COB_NMT && rx_len >= 4'h2 && state != ST_INIT
                    && (rx_data[15:8] == 8'h00 || rx_data[15:8] == {1'b0, node_id});
   assign rst_node = nmt_hit && cmd == `CMD_RST_NODE;

   // mapping tables
   map_slot_t rmap [`MAP_N][`SLOT_N];
   map_slot_t tmap [`MAP_N][`SLOT_N];
   map_slot_t next_rmap [`MAP_N][`SLOT_N];
   map_slot_t next_tmap [`MAP_N][`SLOT_N];
   always_comb begin
      next_rmap = rmap;
      next_tmap = tmap;
      if (map_wr && map_obj < 3'(`MAP_N)) begin
         if (map_tx) begin
            next_tmap[map_obj][map_slot] = map_val;
         end else begin
            next_rmap[map_obj][map_slot] = map_val;
         end
      end
      if (rst_node) begin
         for (int o = 0; o < `MAP_N; o++) begin
            for (int s = 0; s < `SLOT_N; s++) begin
               next_rmap[o][s] = def_map(o, s);
               next_tmap[o][s] = def_map(o, s);
            end
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int o = 0; o < `MAP_N; o++) begin
            for (int s = 0; s < `SLOT_N; s++) begin
               rmap[o][s] <= def_map(o, s);
               tmap[o][s] <= def_map(o, s);
            end
         end
      end else begin
         rmap <= next_rmap;
         tmap <= next_tmap;
      end
   end

   // protocol state, frame builder and outputs
   logic guard_tog, next_guard_tog, guard_req, next_guard_req, sent_on, next_sent_on;
   logic [`MAP_N-1:0] tpend, next_tpend;
   logic [`ERR_N-1:0] reported, next_reported, want, new_rep;
   logic next_tx_valid, tx_done, next_pdo_en, next_svc_en;
   logic [10:0] next_tx_cob;
   logic [3:0] next_tx_len;
   logic [63:0] next_tx_data;
   tx_src_t tx_src, next_tx_src;
   logic [2:0] tx_idx, next_tx_idx;
   logic [8*`DIG_N-1:0] next_dout;
   logic [16*`ANA_N-1:0] next_aout;
   map_slot_t sl;
   int e, pick;
   assign tx_done = tx_valid && tx_ready;
   assign want = err_in ^ reported;
   always_comb begin
      next_state = state;
      next_node_id = node_id;
      next_guard_tog = guard_tog;
      next_guard_req = guard_req;
      next_tpend = tpend;
      next_reported = reported;
      next_sent_on = sent_on;
      next_tx_valid = tx_valid;
      next_tx_cob = tx_cob;
      next_tx_len = tx_len;
      next_tx_data = tx_data;
      next_tx_src = tx_src;
      next_tx_idx = tx_idx;
      next_dout = dout;
      next_aout = aout;
      new_rep = reported;
      sl = '0;
      e = 0;
      pick = 0;
      if (tx_done) begin
         next_tx_valid = 1'b0;
         case (tx_src)
            SRC_BOOT: next_state = ST_PREOP;
            SRC_GUARD: begin
               next_guard_req = 1'b0;
               next_guard_tog = ~guard_tog;
            end
            SRC_EMCY: next_reported[tx_idx[1:0]] = sent_on;
            default: next_tpend[tx_idx] = 1'b0;
         endcase
      end
      // requests arriving now win over the clear above
      for (int o = 0; o < `MAP_N; o++) begin
         if (state == ST_OPER && (tx_trig[o] || (rx_valid && rx_rtr && rx_cob == TX_BASE[o] + id11))) begin
            next_tpend[o] = 1'b1;
         end
      end
      if (rx_valid && rx_rtr && rx_cob == `COB_GUARD + id11 && state != ST_INIT) begin
         next_guard_req = 1'b1;
      end
      if (rx_valid && !rx_rtr && state == ST_OPER) begin
         for (int o = 0; o < `MAP_N; o++) begin
            if (rx_cob == RX_BASE[o] + id11) begin
               for (int s = 0; s < `SLOT_N; s++) begin
                  sl = rmap[o][s];
                  e = int'(sl[4:1]);
                  if (4'(s) < rx_len && sl[6]) begin
                     if (sl[5] && e < `ANA_N) begin
                        next_aout[e*16 + (sl[0] ? 8 : 0) +: 8] = rx_data[s*8 +: 8];
                     end else if (!sl[5] && e < `DIG_N) begin
                        next_dout[e*8 +: 8] = rx_data[s*8 +: 8];
                     end
                  end
               end
            end
         end
      end
      if (nmt_hit) begin
         case (cmd)
            `CMD_START: if (state == ST_PREOP || state == ST_STOP) next_state = ST_OPER;
            `CMD_PREOP: if (state == ST_OPER || state == ST_STOP) next_state = ST_PREOP;
            `CMD_STOP: if (state == ST_PREOP || state == ST_OPER) next_state = ST_STOP;
            `CMD_RST_NODE, `CMD_RST_COMM: next_state = ST_INIT;
            default: ;
         endcase
      end
      if (rst_node) begin
         next_dout = '0;
         next_aout = '0;
      end
      if (state == ST_INIT && !tx_valid) begin
         next_node_id = id_st;
      end
      if (next_state != ST_OPER) begin
         next_tpend = '0;
      end
      if (next_state == ST_INIT) begin
         next_guard_tog = 1'b0;
         next_guard_req = 1'b0;
      end
      if (!tx_valid) begin
         if (state == ST_INIT && node_id != 7'h00) begin
            next_tx_valid = 1'b1;
            next_tx_cob = `COB_GUARD + id11;
            next_tx_len = 4'h1;
            next_tx_data = {56'h0, `BOOT_DATA};
            next_tx_src = SRC_BOOT;
         end else if (guard_req) begin
            next_tx_valid = 1'b1;
            next_tx_cob = `COB_GUARD + id11;
            next_tx_len = 4'h1;
            next_tx_data = {56'h0, guard_tog, state == ST_STOP ? `GS_STOP : state == ST_OPER ? `GS_OPER : `GS_PREOP};
            next_tx_src = SRC_GUARD;
         end else if ((state == ST_PREOP || state == ST_OPER) && |want) begin
            for (int i = `ERR_N-1; i >= 0; i--) begin
               if (want[i]) pick = i;
            end
            new_rep[pick] = err_in[pick];
            next_tx_valid = 1'b1;
            next_tx_cob = `COB_EMCY + id11;
            next_tx_len = `MAX_LEN;
            next_tx_data = {32'h0, 4'h0, new_rep, |new_rep ? `ERR_REG_GEN : 8'h00,
                            err_in[pick] ? ERR_CODE[pick] : 16'h0000};
            next_tx_src = SRC_EMCY;
            next_tx_idx = 3'(pick);
            next_sent_on = err_in[pick];
         end else if (state == ST_OPER && |tpend) begin
            for (int i = `MAP_N-1; i >= 0; i--) begin
               if (tpend[i]) pick = i;
            end
            next_tx_valid = 1'b1;
            next_tx_cob = TX_BASE[pick] + id11;
            next_tx_len = 4'h0;
            next_tx_data = '0;
            next_tx_src = SRC_TPDO;
            next_tx_idx = 3'(pick);
            for (int s = 0; s < `SLOT_N; s++) begin
               sl = tmap[pick][s];
               e = int'(sl[4:1]);
               if (sl[6]) begin
                  next_tx_len = 4'(s + 1);
                  if (sl[5] && e < `ANA_N) begin
                     next_tx_data[s*8 +: 8] = in_st[DW + e*16 + (sl[0] ? 8 : 0) +: 8];
                  end else if (!sl[5] && e < `DIG_N) begin
                     next_tx_data[s*8 +: 8] = in_st[e*8 +: 8];
                  end
               end
            end
         end
      end
      next_pdo_en = next_state == ST_OPER;
      next_svc_en = next_state == ST_OPER || next_state == ST_PREOP;
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nmt_state <= ST_INIT;
         node_id <= 7'h00;
         guard_tog <= 1'b0;
         guard_req <= 1'b0;
         tpend <= '0;
         reported <= '0;
         sent_on <= 1'b0;
         tx_valid <= 1'b0;
         tx_cob <= 11'h000;
         tx_len <= 4'h0;
         tx_data <= '0;
         tx_src <= SRC_BOOT;
         tx_idx <= 3'h0;
         dout <= '0;
         aout <= '0;
         pdo_en <= 1'b0;
         svc_en <= 1'b0;
      end else begin
         nmt_state <= next_state;
         node_id <= next_node_id;
         guard_tog <= next_guard_tog;
         guard_req <= next_guard_req;
         tpend <= next_tpend;
         reported <= next_reported;
         sent_on <= next_sent_on;
         tx_valid <= next_tx_valid;
         tx_cob <= next_tx_cob;
         tx_len <= next_tx_len;
         tx_data <= next_tx_data;
         tx_src <= next_tx_src;
         tx_idx <= next_tx_idx;
         dout <= next_dout;
         aout <= next_aout;
         pdo_en <= next_pdo_en;
         svc_en <= next_svc_en;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_init_on_reset;
      $fell(reset) |-> nmt_state == ST_INIT;
   endproperty
   a_init_on_reset: assert property (p_init_on_reset) else $error("not in init after reset");
   property p_boot_preop;
      tx_done && tx_src == SRC_BOOT |=> nmt_state == ST_PREOP;
   endproperty
   a_boot_preop: assert property (p_boot_preop) else $error("no pre-op after boot-up");
   property p_start;
      nmt_hit && cmd == `CMD_START && (state == ST_PREOP || state == ST_STOP) |=> nmt_state == ST_OPER;
   endproperty
   a_start: assert property (p_start) else $error("start ignored");
   property p_preop;
      nmt_hit && cmd == `CMD_PREOP && (state == ST_OPER || state == ST_STOP) |=> nmt_state == ST_PREOP;
   endproperty
   a_preop: assert property (p_preop) else $error("pre-op ignored");
   property p_stop;
      nmt_hit && cmd == `CMD_STOP && state != ST_STOP |=> nmt_state == ST_STOP;
   endproperty
   a_stop: assert property (p_stop) else $error("stop ignored");
   property p_reset_cmd;
      nmt_hit && (cmd == `CMD_RST_NODE || cmd == `CMD_RST_COMM) |=> nmt_state == ST_INIT ##1 !pdo_en;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored");
   property p_pdo_oper;
      $rose(tx_valid) && tx_src == SRC_TPDO |-> $past(nmt_state) == ST_OPER && tx_len <= `MAX_LEN;
   endproperty
   a_pdo_oper: assert property (p_pdo_oper) else $error("pdo outside operational");
   property p_emcy_clear;
      $rose(tx_valid) && tx_src == SRC_EMCY && !sent_on |-> tx_data[15:0] == 16'h0000 && tx_len == 4'h8;
   endproperty
   a_emcy_clear: assert property (p_emcy_clear) else $error("clear message code not zero");
   property p_emcy_once;
      tx_done && tx_src == SRC_EMCY |=> reported[tx_idx[1:0]] == sent_on ##1 !(tx_valid && $rose(tx_valid)
         && tx_src == SRC_EMCY && tx_idx == $past(tx_idx, 2) && sent_on == $past(sent_on, 2));
   endproperty
   a_emcy_once: assert property (p_emcy_once) else $error("emergency repeated");
   property p_boot_init;
      $rose(tx_valid) && tx_src == SRC_BOOT |-> $past(nmt_state) == ST_INIT && node_id != 7'h00;
   endproperty
   a_boot_init: assert property (p_boot_init) else $error("boot-up outside init");
   c_boot: cover property (tx_done && tx_src == SRC_BOOT);
   c_oper: cover property (nmt_state == ST_PREOP ##1 nmt_state == ST_OPER);
   c_emcy: cover property (tx_done && tx_src == SRC_EMCY && sent_on);
   c_pdo: cover property (tx_done && tx_src == SRC_TPDO);
endmodule
`default_nettype wire

// file: tb/can_master_model.sv
// network master and frame consumer model facing the node's frame ports
`timescale 1ns/1ps
`default_nettype none
module can_master_model (
   // clock
   input wire logic ref_clk,
   // frames from the node
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [10:0] tx_cob,
   input wire logic [3:0] tx_len,
   input wire logic [63:0] tx_data,
   // frames to the node
   output logic rx_valid,
   output logic rx_rtr,
   output logic [10:0] rx_cob,
   output logic [3:0] rx_len,
   output logic [63:0] rx_data
);
   int stall = 0;
   int held = 0;
   logic [78:0] rxq[$];

   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_rtr = 1'b0;
      rx_cob = '0;
      rx_len = '0;
      rx_data = '0;
   end

   // every frame handed over, in order
   always @(posedge ref_clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         rxq.push_back({tx_cob, tx_len, tx_data});
      end
   end

   // ready only after the programmed number of stall cycles
   always @(posedge ref_clk) begin
      #1;
      held = (tx_valid === 1'b1) ? held + 1 : 0;
      tx_ready = (tx_valid === 1'b1) && (held > stall);
   end

   // one frame from the single master, addressed by node id; lines scrambled after
   task automatic send(input logic [10:0] cob, input logic [3:0] len, input logic [63:0] data,
                       input logic rtr);
      @(posedge ref_clk);
      #1;
      rx_valid = 1'b1;
      rx_rtr = rtr;
      rx_cob = cob;
      rx_len = len;
      rx_data = data;
      @(posedge ref_clk);
      #1;
      rx_valid = 1'b0;
      rx_rtr = ~rtr;
      rx_cob = ~cob;
      rx_len = ~len;
      rx_data = ~data;
   endtask
endmodule
`default_nettype wire

// file: tb/canopen_node_bench.sv
// self-checking testbench of the canopen slave node
`timescale 1ns/1ps
`default_nettype none
`include "canopen_node_params.svh"
module canopen_node_bench;
   import canopen_node_pkg::*;
   localparam logic [6:0] NODE_ID = 7'h05;
   localparam logic [10:0] ID = {4'h0, NODE_ID};
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [8*`DIG_N-1:0] din_pin;
   logic [16*`ANA_N-1:0] ain_pin;
   logic [`MAP_N-1:0] tx_trig = '0;
   logic [`ERR_N-1:0] err_in = '0;
   logic map_wr = 1'b0;
   logic map_tx = 1'b0;
   logic [2:0] map_obj = 3'h0;
   logic [2:0] map_slot = 3'h0;
   map_slot_t map_val = '0;
   wire logic rx_valid;
   wire logic rx_rtr;
   wire logic [10:0] rx_cob;
   wire logic [3:0] rx_len;
   wire logic [63:0] rx_data;
   wire logic tx_valid;
   wire logic tx_ready;
   wire logic [10:0] tx_cob;
   wire logic [3:0] tx_len;
   wire logic [63:0] tx_data;
   wire logic [8*`DIG_N-1:0] dout;
   wire logic [16*`ANA_N-1:0] aout;
   nmt_state_t nmt_state;
   wire logic pdo_en;
   wire logic svc_en;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [10:0] tcob [6] = '{`TPDO1, `TPDO2, `TPDO3, `TPDO4, `TPDO5, `TPDO6};
   logic [3:0] tlen [6] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h3, 4'h2};
   logic [63:0] tdat [6];
   logic [63:0] d1;

   canopen_node canopen_node_i (.ref_clk(ref_clk), .reset(reset), .node_id_pin(NODE_ID), .din_pin(din_pin),
      .ain_pin(ain_pin), .tx_trig(tx_trig), .err_in(err_in), .map_wr(map_wr), .map_tx(map_tx), .map_obj(map_obj),
      .map_slot(map_slot), .map_val(map_val), .rx_valid(rx_valid), .rx_rtr(rx_rtr), .rx_cob(rx_cob),
      .rx_len(rx_len), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_cob(tx_cob),
      .tx_len(tx_len), .tx_data(tx_data), .dout(dout), .aout(aout), .nmt_state(nmt_state), .pdo_en(pdo_en),
      .svc_en(svc_en));
   can_master_model can_master_model_i (.ref_clk(ref_clk), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_cob(tx_cob), .tx_len(tx_len), .tx_data(tx_data), .rx_valid(rx_valid), .rx_rtr(rx_rtr),
      .rx_cob(rx_cob), .rx_len(rx_len), .rx_data(rx_data));

   always #2.5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic summarize();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic ckst(input nmt_state_t s, input logic p, input logic v);
      check({60'h0, nmt_state, pdo_en, svc_en}, {60'h0, s, p, v});
   endtask

   task automatic expect_frame(input logic [10:0] base, input logic [3:0] len, input logic [63:0] data);
      logic [78:0] f;
      int i;
      i = 0;
      while (can_master_model_i.rxq.size() == 0 && i < 400) begin
         @(posedge ref_clk);
         #1;
         i++;
      end
      if (can_master_model_i.rxq.size() == 0) begin
         check(64'h0, 64'h1);
      end else begin
         f = can_master_model_i.rxq.pop_front();
         check({49'h0, f[78:64]}, {49'h0, base + ID, len});
         check(f[63:0], data);
      end
   endtask

   task automatic quiet(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
      check(64'(can_master_model_i.rxq.size()), 64'h0);
   endtask

   task automatic rx(input logic [10:0] cob, input logic [3:0] len, input logic [63:0] data, input logic rtr);
      can_master_model_i.send(cob, len, data, rtr);
      @(posedge ref_clk);
      #1;
   endtask

   task automatic nmt(input logic [7:0] cmd);
      rx(`COB_NMT, 4'h2, {48'h0, 1'b0, NODE_ID, cmd}, 1'b0);
   endtask

   task automatic guard(input logic [7:0] exp);
      rx(`COB_GUARD + ID, 4'h0, 64'h0, 1'b1);
      expect_frame(`COB_GUARD, 4'h1, {56'h0, exp});
   endtask

   task automatic trig(input logic [5:0] m);
      @(posedge ref_clk);
      #1;
      tx_trig = m;
      @(posedge ref_clk);
      #1;
      tx_trig = '0;
   endtask

   task automatic boot();
      expect_frame(`COB_GUARD, 4'h1, {56'h0, `BOOT_DATA});
      @(posedge ref_clk);
      #1;
      ckst(ST_PREOP, 1'b0, 1'b1);
   endtask

   task automatic t_states();
      guard(8'h7F);
      guard(8'hFF);
      trig(6'h01);
      rx(`RPDO1 + ID, 4'h8, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
      quiet(20);
      check(dout[63:0], 64'h0);
      nmt(`CMD_START);
      ckst(ST_OPER, 1'b1, 1'b1);
      guard(8'h05);
      nmt(`CMD_STOP);
      ckst(ST_STOP, 1'b0, 1'b0);
      guard(8'h84);
      nmt(`CMD_START);
      ckst(ST_OPER, 1'b1, 1'b1);
      nmt(`CMD_PREOP);
      ckst(ST_PREOP, 1'b0, 1'b1);
      nmt(`CMD_STOP);
      ckst(ST_STOP, 1'b0, 1'b0);
      // broadcast form, node field zero
      rx(`COB_NMT, 4'h2, {48'h0, 8'h00, `CMD_PREOP}, 1'b0);
      ckst(ST_PREOP, 1'b0, 1'b1);
      nmt(`CMD_STOP);
      nmt(`CMD_RST_COMM);
      ckst(ST_INIT, 1'b0, 1'b0);
      boot();
      guard(8'h7F);
   endtask

   task automatic t_pdo();
      nmt(`CMD_START);
      for (int o = 0; o < 6; o++) begin
         can_master_model_i.stall = o;
         trig(6'(1 << o));
         expect_frame(tcob[o], tlen[o], tdat[o]);
      end
      trig(6'h21);
      expect_frame(tcob[0], tlen[0], tdat[0]);
      expect_frame(tcob[5], tlen[5], tdat[5]);
      // remote request on the second transmit object
      rx(`TPDO2 + ID, 4'h0, 64'h0, 1'b1);
      expect_frame(tcob[1], tlen[1], tdat[1]);
      d1 = 64'h8877_6655_4433_2211;
      rx(`RPDO1 + ID, 4'h8, d1, 1'b0);
      check(dout[63:0], d1);
      rx(`RPDO5 + ID, 4'h3, 64'h0000_0000_00C0_FFEE, 1'b0);
      check({40'h0, dout[87:64]}, 64'h0000_0000_00C0_FFEE);
      rx(`RPDO2 + ID, 4'h2, 64'h5555_5555_5555_BEEF, 1'b0);
      check(aout[63:0], 64'h0000_0000_0000_BEEF);
      rx(`RPDO6 + ID, 4'h2, 64'h0000_0000_0000_1234, 1'b0);
      check({48'h0, aout[207:192]}, 64'h0000_0000_0000_1234);
   endtask

   task automatic t_map();
      @(posedge ref_clk);
      #1;
      map_wr = 1'b1;
      map_val = 7'h52;
      @(posedge ref_clk);
      #1;
      // second edge writes the same slot of the transmit table
      map_tx = 1'b1;
      @(posedge ref_clk);
      #1;
      map_wr = 1'b0;
      map_tx = 1'b0;
      rx(`RPDO1 + ID, 4'h1, 64'h0000_0000_0000_00C3, 1'b0);
      check({48'h0, dout[79:72], dout[7:0]}, 64'h0000_0000_0000_C311);
      trig(6'h01);
      expect_frame(`TPDO1, 4'h8, {din_pin[63:8], 8'h19});
      nmt(`CMD_RST_NODE);
      ckst(ST_INIT, 1'b0, 1'b0);
      check(dout[63:0] | {40'h0, dout[87:64]}, 64'h0);
      boot();
      // default mappings back after reset node
      nmt(`CMD_START);
      trig(6'h01);
      expect_frame(`TPDO1, 4'h8, tdat[0]);
      rx(`RPDO1 + ID, 4'h1, 64'h0000_0000_0000_00C3, 1'b0);
      check({48'h0, dout[79:72], dout[7:0]}, 64'h0000_0000_0000_00C3);
   endtask

   task automatic t_emcy();
      @(posedge ref_clk);
      #1;
      err_in = 4'h2;
      expect_frame(`COB_EMCY, 4'h8, 64'h0000_0000_0201_2000);
      quiet(40);
      err_in = 4'h0;
      expect_frame(`COB_EMCY, 4'h8, 64'h0);
   endtask

   initial begin
      for (int k = 0; k < `DIG_N; k++) din_pin[8*k+:8] = 8'h10 + 8'(k);
      for (int k = 0; k < `ANA_N; k++) ain_pin[16*k+:16] = 16'hA001 + 16'(k * 258);
      tdat = '{din_pin[63:0], ain_pin[63:0], ain_pin[127:64], ain_pin[191:128], {40'h0, din_pin[87:64]},
               {48'h0, ain_pin[207:192]}};
      repeat (10) @(posedge ref_clk);
      #1;
      ckst(ST_INIT, 1'b0, 1'b0);
      reset = 1'b0;
      boot();
      t_states();
      t_pdo();
      t_map();
      t_emcy();
      summarize();
   end
endmodule
`default_nettype wire
